// *** rtl/hdbb_pkg.sv ***
// Purpose: Shared constants and carriers for the host DMA bus bridge
// Assumes: 50 MHz system clock, all bus timing signals sampled
// Notes:   Window bounds compare against the host byte address
package hdbb_pkg;
  localparam logic [23:0] WIN_LO       = 24'h040000;
  localparam logic [23:0] WIN_HI       = 24'h05FFFF;
  localparam int          ADDR_OUT_W   = 15;
  localparam int          SEL_BIT      = 16;
  localparam int          CAS_LEAD_NS  = 100;
  localparam int          CLK_NS       = 20;
  localparam int          CAS_LEAD_CYC = CAS_LEAD_NS / CLK_NS;
  localparam logic        LANE_RST     = 1'b0;

  // Timing set of one bus CPU
  typedef struct packed {
    logic phase2;      // Phase-2 clock
    logic release_ack; // Stall / release acknowledge
    logic chain_in;    // Chain enable in, active low
    logic phase_ref;   // Bus phase reference
    logic col_strobe;  // Buffered column strobe
  } hdbb_cpu_type;

  // Host request bundle
  typedef struct packed {
    logic [23:1] addr;
    logic        as_n;
    logic        uds_n;
    logic        lds_n;
    logic        rd_wr;
    logic [15:0] wdata;
  } hdbb_host_type;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_REQ  = 4'b0010,
    ST_CYC  = 4'b0100,
    ST_DONE = 4'b1000
  } hdbb_state_type;
endpackage : hdbb_pkg

// *** rtl/hdbb_bridge.sv ***
// Purpose: Steals bus CPU cycles to carry 16-bit host accesses as bytes
// Assumes: Host and bus pins asynchronous; each passes two flops first
// Notes:   Open-collector request modelled as output plus enable
// Function
// RULE_01 - Host access in the DMA window asserts the active-low window select
// RULE_02 - Address bit sixteen picks which bus CPU timing set is used
// RULE_03 - Selected phase-2 rising edge latches pending window select
// RULE_04 - With request latched and chain-in low, pull shared request low
// RULE_05 - Chain-out follows chain-in unless requesting, then held high
// RULE_06 - Bus CPU acknowledge line serves as the bridge's bus grant
// RULE_07 - Grant rise with request and chain enabled sets cycle pending
// RULE_08 - Same grant edge asserts memory-map claim for selected CPU
// RULE_09 - Address phase drives low 15 address bits, valid address, direction
// RULE_10 - Strobes captured into lane flags at cycle start; lower drives A0 (code: byte accesses only; a word access keeps the prior flags)
// RULE_11 - Word access makes two byte transfers, toggling lane flags between
// RULE_12 - Data-phase drive rises at phase reference edge during a cycle
// RULE_13 - On writes the chosen byte lane buffer is enabled through the cycle
// RULE_14 - Read latch pulse on column strobe, gated by lane flag, grabs byte
// RULE_15 - Latched read byte held on host lane until window select negates
// RULE_16 - Single-byte access acknowledged at the first latch pulse
// RULE_17 - Word access acknowledged only at the second latch pulse
// RULE_18 - Address strobe release clears termination flops for next access
// RULE_19 - Reset returns all request, chain, phase and lane flops to idle
`timescale 1ns/1ps
`default_nettype none
module hdbb_bridge (
  input  wire logic                 clk_sys,             // System clock
  input  wire logic                 rst,                 // Async reset
  input  wire logic                 clk_en,              // Freezes state low
  input  wire hdbb_pkg::hdbb_host_type host,             // Host bus
  input  wire hdbb_pkg::hdbb_cpu_type  cpu_a,            // First CPU timing
  input  wire hdbb_pkg::hdbb_cpu_type  cpu_b,            // Second CPU timing
  input  wire logic [7:0]           sys_data_in,         // System data in
  output logic                      dma_window_select_n, // Window select
  output logic                      shared_dma_request,  // Request level, 0
  output logic                      shared_dma_req_oe,   // Pulls line low
  output logic                      chain_enable_out_a,  // Chain out CPU A
  output logic                      chain_enable_out_b,  // Chain out CPU B
  output logic                      dma_cycle_pending,   // Cycle pending
  output logic                      memory_map_claim_a,  // Claim CPU A
  output logic                      memory_map_claim_b,  // Claim CPU B
  output logic                      address_phase_drive, // Address enable
  output logic [14:0]               sys_addr,            // System address
  output logic                      valid_memory_address,// Valid address
  output logic                      sys_rd_wr,           // Bus direction
  output logic                      data_phase_drive,    // Transceiver enable
  output logic [7:0]                sys_data_out,        // Write byte
  output logic                      latch_data_pulse,    // Read latch pulse
  output logic [15:0]               host_rdata,          // Read data to host
  output logic                      host_rdata_oe_hi,    // Upper lane drive
  output logic                      host_rdata_oe_lo,    // Lower lane drive
  output logic                      host_transfer_ack_n  // Transfer ack
);
  import hdbb_pkg::*;

  // Two-flop synchronisers for all foreign inputs
  hdbb_host_type host_s1, host_q;
  hdbb_cpu_type  a_s1, a_q, b_s1, b_q;
  logic [7:0]    data_s1, data_q;
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      host_s1 <= '1;
      host_q  <= '1;
      a_s1    <= '0;
      a_q     <= '0;
      b_s1    <= '0;
      b_q     <= '0;
      data_s1 <= '0;
      data_q  <= '0;
    end else if (clk_en) begin
      host_s1 <= host;
      host_q  <= host_s1;
      a_s1    <= cpu_a;
      a_q     <= a_s1;
      b_s1    <= cpu_b;
      b_q     <= b_s1;
      data_s1 <= sys_data_in;
      data_q  <= data_s1;
    end
  end

  // Window decode and CPU selection
  logic [23:0]  host_byte_addr;
  logic         in_window;
  logic         sel_a;
  hdbb_cpu_type cpu;
  assign host_byte_addr = {host_q.addr, 1'b0};
  assign in_window = !host_q.as_n && (host_byte_addr >= WIN_LO)
                     && (host_byte_addr <= WIN_HI);                 // RULE_01
  assign sel_a = host_q.addr[SEL_BIT];                              // RULE_02
  assign cpu   = sel_a ? a_q : b_q;                                 // RULE_02

  // Previous values for edge detection; a change of address bit 16
  // mid-access can fake one edge, so the host must hold its address
  hdbb_cpu_type cpu_d;
  logic         as_d;
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cpu_d <= '0;
      as_d  <= 1'b1;
    end else if (clk_en) begin
      cpu_d <= cpu;
      as_d  <= host_q.as_n;
    end
  end
  logic p2_rise, grant_rise, ref_rise, cas_rise, as_end;
  assign p2_rise    = cpu.phase2 && !cpu_d.phase2;
  assign grant_rise = cpu.release_ack && !cpu_d.release_ack;        // RULE_06
  assign ref_rise   = cpu.phase_ref && !cpu_d.phase_ref;
  assign cas_rise   = cpu.col_strobe && !cpu_d.col_strobe;
  assign as_end     = host_q.as_n && !as_d;

  logic word_acc;
  assign word_acc = !host_q.uds_n && !host_q.lds_n;

  // Window select pin
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      dma_window_select_n <= 1'b1;                                  // RULE_19
    end else if (clk_en) begin
      dma_window_select_n <= !in_window;                            // RULE_01
    end
  end

  // Transfer sequencer
  hdbb_state_type state;
  logic           req_latched;
  logic [1:0]     xfer_done;
  logic           upper_lane_flag, lower_lane_flag;
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state       <= ST_IDLE;                                       // RULE_19
      req_latched <= 1'b0;
    end else if (clk_en) begin
      case (state)
        ST_IDLE: begin
          if (in_window && p2_rise) begin
            req_latched <= 1'b1;                                    // RULE_03
            state       <= ST_REQ;
          end
        end
        ST_REQ: begin
          if (!in_window) begin
            req_latched <= 1'b0;
            state       <= ST_IDLE;
          end else if (grant_rise && !cpu.chain_in) begin
            state <= ST_CYC;                                        // RULE_07
          end
        end
        ST_CYC: begin
          if (cas_rise) begin
            req_latched <= 1'b0;
            state       <= ST_DONE;
          end
        end
        ST_DONE: begin
          if (!in_window || as_end) begin
            state <= ST_IDLE;                                       // RULE_18
          end else if (word_acc && xfer_done == 2'b01) begin
            state <= ST_IDLE;                                       // RULE_17
          end
        end
        default: begin
          state       <= ST_IDLE;
          req_latched <= 1'b0;
        end
      endcase
    end
  end

  // Request and chain pass-through
  logic requesting;
  assign requesting = req_latched && (state == ST_REQ);
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      shared_dma_request <= 1'b0;
      shared_dma_req_oe  <= 1'b0;
      chain_enable_out_a <= 1'b1;
      chain_enable_out_b <= 1'b1;
    end else if (clk_en) begin
      shared_dma_request <= 1'b0;
      shared_dma_req_oe  <= requesting && !cpu.chain_in;            // RULE_04
      chain_enable_out_a <= (requesting && sel_a) ? 1'b1
                            : a_q.chain_in;                         // RULE_05
      chain_enable_out_b <= (requesting && !sel_a) ? 1'b1
                            : b_q.chain_in;                         // RULE_05
    end
  end

  // Cycle pending, claim, address and data phase
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      dma_cycle_pending   <= 1'b0;
      memory_map_claim_a  <= 1'b0;
      memory_map_claim_b  <= 1'b0;
      address_phase_drive <= 1'b0;
      data_phase_drive    <= 1'b0;
    end else if (clk_en) begin
      if (state == ST_REQ && grant_rise && !cpu.chain_in) begin
        dma_cycle_pending  <= 1'b1;                                 // RULE_07
        memory_map_claim_a <= sel_a;                                // RULE_08
        memory_map_claim_b <= !sel_a;                               // RULE_08
      end else if (state == ST_CYC && ref_rise) begin
        dma_cycle_pending  <= 1'b0;                                 // RULE_07
        memory_map_claim_a <= 1'b0;
        memory_map_claim_b <= 1'b0;
      end
      if (state == ST_CYC && ref_rise) begin
        address_phase_drive <= 1'b1;                                // RULE_09
        data_phase_drive    <= 1'b1;                                // RULE_12
      end else if (state != ST_CYC) begin
        address_phase_drive <= 1'b0;
        data_phase_drive    <= 1'b0;
      end
    end
  end

  // Address, direction and write byte to the system bus
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sys_addr             <= '0;
      valid_memory_address <= 1'b0;
      sys_rd_wr            <= 1'b1;
      sys_data_out         <= '0;
    end else if (clk_en) begin
      sys_addr <= {host_q.addr[ADDR_OUT_W-1:1], lower_lane_flag};   // RULE_10
      valid_memory_address <= (state == ST_CYC);                    // RULE_09
      sys_rd_wr            <= host_q.rd_wr;                         // RULE_09
      if (!host_q.rd_wr && in_window && state == ST_CYC) begin
        sys_data_out <= upper_lane_flag ? host_q.wdata[15:8]
                                        : host_q.wdata[7:0];        // RULE_13
      end
    end
  end

  // Lane flags: captured at cycle start of byte accesses, toggled between word halves
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      upper_lane_flag <= LANE_RST;                                  // RULE_19
      lower_lane_flag <= !LANE_RST;
    end else if (clk_en) begin
      if (state == ST_REQ && grant_rise && !cpu.chain_in) begin
        if (word_acc) begin
          if (xfer_done != 2'b00) begin
            upper_lane_flag <= !upper_lane_flag;                    // RULE_11
            lower_lane_flag <= !lower_lane_flag;                    // RULE_11
          end
        end else begin
          upper_lane_flag <= !host_q.uds_n;                         // RULE_10
          lower_lane_flag <= !host_q.lds_n;                         // RULE_10
        end
      end
    end
  end

  // Read latch pulse and read data hold; a strobe that lands as the
  // window drops wins for one cycle, the level clear follows next cycle
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      latch_data_pulse <= 1'b0;
      host_rdata       <= '0;
      host_rdata_oe_hi <= 1'b0;
      host_rdata_oe_lo <= 1'b0;
    end else if (clk_en) begin
      latch_data_pulse <= (state == ST_CYC) && cas_rise;            // RULE_14
      if (!in_window) begin
        host_rdata_oe_hi <= 1'b0;                                   // RULE_15
        host_rdata_oe_lo <= 1'b0;
      end
      if (state == ST_CYC && cas_rise && host_q.rd_wr) begin
        if (upper_lane_flag) begin
          host_rdata[15:8] <= data_q;                               // RULE_14
          host_rdata_oe_hi <= 1'b1;                                 // RULE_15
        end
        if (lower_lane_flag) begin
          host_rdata[7:0]  <= data_q;                               // RULE_14
          host_rdata_oe_lo <= 1'b1;                                 // RULE_15
        end
      end
    end
  end

  // Termination: count byte transfers, acknowledge at the last one
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      xfer_done           <= 2'b00;
      host_transfer_ack_n <= 1'b1;
    end else if (clk_en) begin
      if (!in_window) begin
        xfer_done           <= 2'b00;                               // RULE_18
        host_transfer_ack_n <= 1'b1;                                // RULE_18
      end
      if (state == ST_CYC && cas_rise) begin
        xfer_done <= {xfer_done[0], 1'b1};
        if (!word_acc || xfer_done[0]) begin
          host_transfer_ack_n <= 1'b0;                     // RULE_16 RULE_17
        end
      end
    end
  end
endmodule : hdbb_bridge
`default_nettype wire

// *** verif/hdbb_checker.sv ***
// Purpose: Port checks for the bridge
// Assumes: All ports sampled on clk_sys
// Notes:   Bound into every bridge instance
`timescale 1ns/1ps
`default_nettype none
module hdbb_checker
  import hdbb_pkg::*;
(
  input wire logic          clk_sys,             // Clock
  input wire logic          rst,                 // Reset
  input wire logic          clk_en,              // Run enable
  input wire hdbb_pkg::hdbb_host_type host,      // Host bus
  input wire hdbb_pkg::hdbb_cpu_type  cpu_b,     // Second CPU
  input wire logic          dma_window_select_n, // Window
  input wire logic          shared_dma_req_oe,   // Request
  input wire logic          chain_enable_out_a,  // Chain A
  input wire logic          chain_enable_out_b,  // Chain B
  input wire logic          dma_cycle_pending,   // Pending
  input wire logic          memory_map_claim_a,  // Claim A
  input wire logic          memory_map_claim_b,  // Claim B
  input wire logic          address_phase_drive, // Address
  input wire logic [14:0]   sys_addr,            // Bus address
  input wire logic          valid_memory_address,// Valid
  input wire logic          sys_rd_wr,           // Direction
  input wire logic          data_phase_drive,    // Data phase
  input wire logic          latch_data_pulse,    // Latch
  input wire logic [15:0]   host_rdata,          // Read data
  input wire logic          host_transfer_ack_n  // Ack
);
  logic [1:0] pulses;
  logic       in_win;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst || !clk_en);
  // Host address inside the window
  assign in_win = {host.addr, 1'b0} >= WIN_LO && {host.addr, 1'b0} <= WIN_HI;
  // Latch pulses seen in the current access
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst || dma_window_select_n)
      pulses <= 2'h0;
    else if (latch_data_pulse)
      pulses <= pulses + 2'h1;
  end
  sequence s_in_win;
    (!host.as_n && in_win) [*4];
  endsequence
  sequence s_grant;
    $rose(dma_cycle_pending);
  endsequence
  a_window_sel: assert property (s_in_win |-> !dma_window_select_n)
    else $error("window select missing");
  a_req_window: assert property ($rose(shared_dma_req_oe)
    |-> !dma_window_select_n) else $error("request outside window");
  a_chain_hold: assert property (shared_dma_req_oe
    |-> (host.addr[16] ? chain_enable_out_a : chain_enable_out_b))
    else $error("chain not held");
  a_chain_pass: assert property ((dma_window_select_n
    && !cpu_b.chain_in) [*6] |-> !chain_enable_out_b)
    else $error("chain not passed");
  a_grant_claim: assert property (s_grant |-> $past(shared_dma_req_oe)
    && memory_map_claim_a == host.addr[16]
    && memory_map_claim_b == !host.addr[16]) else $error("bad claim");
  a_addr_phase: assert property (address_phase_drive
    |-> valid_memory_address && sys_addr[14:1] == host.addr[14:1]
    && sys_rd_wr == host.rd_wr) else $error("bad address phase");
  a_data_phase: assert property ($rose(data_phase_drive)
    |-> $past(dma_cycle_pending)) else $error("data phase early");
  a_latch_once: assert property (latch_data_pulse |=> !latch_data_pulse)
    else $error("latch pulse too long");
  a_ack_count: assert property ($fell(host_transfer_ack_n)
    |-> int'(pulses) + int'(latch_data_pulse)
    == ((!host.uds_n && !host.lds_n) ? 2 : 1)) else $error("ack count");
  a_ack_stands: assert property (!host_transfer_ack_n && !host.as_n
    |=> !host_transfer_ack_n && $stable(host_rdata)) else $error("ack drop");
  a_reset_idle: assert property ($fell(rst) |-> host_transfer_ack_n
    && !shared_dma_req_oe && !dma_cycle_pending) else $error("not idle");
endmodule : hdbb_checker
bind hdbb_bridge hdbb_checker chk (.*);
`default_nettype wire

// *** verif/hdbb_cpu_model.sv ***
// Purpose: One bus CPU with its chain, grant and strobes
// Assumes: Phase-2 period of 160 ns, eight system clocks
// Notes:   Read byte is the bus address xor 5A
`timescale 1ns/1ps
`default_nettype none
module hdbb_cpu_model
  import hdbb_pkg::*;
#(parameter int LAG = 2)
(
  input  wire logic         clk_sys,      // Clock
  input  wire logic         req,          // Shared request pulled
  input  wire logic         block,        // Higher level busy
  input  wire logic         chain_out,    // Bridge chain out
  input  wire logic [14:0]  sys_addr,     // Bus address
  input  wire logic         sys_rd_wr,    // Direction
  input  wire logic [7:0]   sys_data_out, // Write byte
  output wire hdbb_pkg::hdbb_cpu_type cpu, // Timing set
  output logic [7:0]        data,         // Read byte
  output logic [15:0]       wr_data       // Bytes written
);
  logic [2:0] cnt = 3'h0;
  logic       ack = 1'b0;
  logic       pref = 1'b0;
  logic       cas = 1'b0;
  assign cpu = '{cnt[2], ack, block, pref, cas};
  // Free running phase-2
  always @(posedge clk_sys) cnt <= cnt + 3'h1;
  // Grant, phase reference, column strobe
  initial begin
    data = 8'hC3;
    wr_data = 16'h0000;
    forever begin
      @(posedge clk_sys);
      if (req && chain_out && !block) begin
        repeat (LAG) @(posedge clk_sys);
        ack <= 1'b1;
        repeat (6) @(posedge clk_sys);
        ack <= 1'b0;
        pref <= 1'b1;
        repeat (6) @(posedge clk_sys);
        data <= sys_addr[7:0] ^ 8'h5A;
        if (!sys_rd_wr && sys_addr[0])
          wr_data[7:0] <= sys_data_out;
        if (!sys_rd_wr && !sys_addr[0])
          wr_data[15:8] <= sys_data_out;
        cas <= 1'b1;
        repeat (4) @(posedge clk_sys);
        pref <= 1'b0;
        cas <= 1'b0;
        data <= ~data; // Released bus shows no stale byte
        repeat (8) @(posedge clk_sys);
      end
    end
  end
endmodule : hdbb_cpu_model
`default_nettype wire

// *** verif/hdbb_bridge_tb.sv ***
// Purpose: Self-checking bench for the bridge
// Assumes: Two CPU models, one prompt and one slow
// Notes:   Read data is checked by lane, order free
`timescale 1ns/1ps
`default_nettype none
module hdbb_bridge_tb;
  import hdbb_pkg::*;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic clk_en = 1'b1;
  logic block_a = 1'b0;
  logic block_b = 1'b0;
  logic [1:0] seen = 2'h0;
  logic [1:0] oe;
  logic [1:0] cl;
  logic [15:0] rd;
  hdbb_host_type host;
  wire hdbb_cpu_type cpu_a, cpu_b;
  logic [7:0] sys_data_in, da, db, sys_data_out;
  logic [15:0] wa, wb, host_rdata;
  logic [14:0] sys_addr;
  logic dma_window_select_n, shared_dma_request, shared_dma_req_oe;
  logic chain_enable_out_a, chain_enable_out_b, dma_cycle_pending;
  logic memory_map_claim_a, memory_map_claim_b, address_phase_drive;
  logic valid_memory_address, sys_rd_wr, data_phase_drive;
  logic latch_data_pulse, host_rdata_oe_hi, host_rdata_oe_lo;
  logic host_transfer_ack_n;
  int err_total = 0;
  int checks = 0;
  hdbb_bridge uut (.*);
  hdbb_cpu_model #(.LAG(2)) cpu_first (.clk_sys, .req(shared_dma_req_oe),
    .block(block_a), .chain_out(chain_enable_out_a), .sys_addr, .sys_rd_wr,
    .sys_data_out, .cpu(cpu_a), .data(da), .wr_data(wa));
  hdbb_cpu_model #(.LAG(20)) cpu_second (.clk_sys, .req(shared_dma_req_oe),
    .block(block_b), .chain_out(chain_enable_out_b), .sys_addr, .sys_rd_wr,
    .sys_data_out, .cpu(cpu_b), .data(db), .wr_data(wb));
  assign sys_data_in = host.addr[16] ? da : db;
  always #10 clk_sys = ~clk_sys;
  // Claims seen during the current access
  always @(posedge clk_sys)
    seen <= host.as_n ? 2'h0 : seen | {memory_map_claim_a, memory_map_claim_b};
  task automatic chk(input string what, input logic [15:0] e, input logic [15:0] g);
    checks++;
    if (g !== e) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", what, e, g);
    end
  endtask : chk
  task automatic start(input logic [23:0] a, input logic r, input logic [1:0] ds,
                       input logic [15:0] wd);
    @(posedge clk_sys);
    host <= '{a[23:1], 1'b0, ds[1], ds[0], r, wd};
  endtask : start
  task automatic finish();
    for (int n = 0; n < 900 && host_transfer_ack_n !== 1'b0; n++) begin
      @(posedge clk_sys);
      #1;
    end
    rd = host_rdata;
    oe = {host_rdata_oe_hi, host_rdata_oe_lo};
    cl = seen;
    chk("ack", 16'h0000, {15'h0000, host_transfer_ack_n});
    @(posedge clk_sys);
    host.as_n <= 1'b1;
    repeat (8) @(posedge clk_sys);
    #1 chk("ack release", 16'h0001, {15'h0000, host_transfer_ack_n});
  endtask : finish
  task automatic t_read(input logic [23:0] a, input logic [1:0] ds);
    logic [15:0] m;
    m = {{8{!ds[1]}}, {8{!ds[0]}}};
    start(a, 1'b1, ds, 16'h0000);
    finish();
    chk("read", ({a[7:1], 1'b0, a[7:1], 1'b1} ^ 16'h5A5A) & m,
        rd & m);
    chk("lanes", {14'h0000, ~ds}, {14'h0000, oe});
    chk("claim", {14'h0000, a[16], !a[16]}, {14'h0000, cl});
  endtask : t_read
  task automatic t_write(input logic [23:0] a, input logic [1:0] ds,
                         input logic [15:0] wd);
    logic [15:0] m;
    m = {{8{!ds[1]}}, {8{!ds[0]}}};
    start(a, 1'b0, ds, wd);
    finish();
    chk("write", wd & m, (a[16] ? wa : wb) & m);
  endtask : t_write
  task automatic t_blocked();
    @(posedge clk_sys);
    block_a <= 1'b1;
    start(24'h051000, 1'b1, 2'h0, 16'h0000);
    repeat (60) @(posedge clk_sys);
    #1 chk("held", 16'h0003, {seen, shared_dma_req_oe, chain_enable_out_a,
                              host_transfer_ack_n});
    @(posedge clk_sys);
    block_a <= 1'b0;
    finish();
    chk("late read", 16'h5A5B, rd);
  endtask : t_blocked
  task automatic t_frozen();
    @(posedge clk_sys);
    clk_en <= 1'b0;
    start(24'h050012, 1'b1, 2'h1, 16'h0000);
    repeat (20) @(posedge clk_sys);
    #1 chk("frozen", 16'h0001, {15'h0000, dma_window_select_n});
    @(posedge clk_sys);
    clk_en <= 1'b1;
    finish();
    chk("thawed read", 16'h4800, rd & 16'hFF00);
  endtask : t_frozen
  task automatic t_outside(input logic [23:0] a);
    start(a, 1'b1, 2'h0, 16'h0000);
    repeat (12) @(posedge clk_sys);
    #1 chk("outside", 16'h0002, {dma_window_select_n, shared_dma_req_oe});
    @(posedge clk_sys);
    host.as_n <= 1'b1;
  endtask : t_outside
  task automatic wrap_up();
    $display("checks %0d err_total %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : wrap_up
  // Main sequence
  initial begin
    host = '{23'h000000, 1'b1, 1'b1, 1'b1, 1'b1, 16'h0000};
    repeat (9) @(posedge clk_sys);
    #1 chk("reset", 16'h0036, {dma_window_select_n, host_transfer_ack_n,
      shared_dma_req_oe, chain_enable_out_a, chain_enable_out_b,
      dma_cycle_pending});
    @(posedge clk_sys);
    rst <= 1'b0;
    repeat (4) @(posedge clk_sys);
    t_outside(24'h060000);
    t_outside(24'h03FFFE);
    t_read(24'h050012, 2'h1);
    t_read(24'h04ABC4, 2'h2);
    t_read(24'h05FFFE, 2'h0);
    t_read(24'h040000, 2'h0);
    t_write(24'h051234, 2'h0, 16'hA55A);
    t_write(24'h04AAA0, 2'h1, 16'h3CC3);
    t_blocked();
    t_frozen();
    wrap_up();
  end
  // Watchdog
  initial begin
    #400000;
    err_total++;
    wrap_up();
  end
endmodule : hdbb_bridge_tb
`default_nettype wire
